// *** hdl/ppm_top.v ***
// Three-port parallel port with basic, strobed and bidirectional modes
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"

module ppm_top (
    input  wire       clk,
    input  wire       nrst,
    input  wire       ce,
    input  wire [1:0] port_select,
    input  wire [7:0] wr_data,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rd_data,
    input  wire [7:0] first_port_line_in,
    output reg  [7:0] first_port_line_out,
    output reg  [7:0] first_port_line_oe_n,
    input  wire [7:0] second_port_line_in,
    output reg  [7:0] second_port_line_out,
    output reg  [7:0] second_port_line_oe_n,
    input  wire [7:0] third_port_line_in,
    output reg  [7:0] third_port_line_out,
    output reg  [7:0] third_port_line_oe_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire [23:0] pins_s;
    wire [7:0]  pa_s;
    wire [7:0]  pb_s;
    wire [7:0]  pc_s;

    reg  [1:0]  a_mode_r;
    reg         b_mode_r;
    reg         a_dir_in_r;
    reg         b_dir_in_r;
    reg         cu_dir_in_r;
    reg         cl_dir_in_r;

    reg  [7:0]  a_in_r;
    reg  [7:0]  b_in_r;
    reg  [7:0]  b_out_r;
    reg  [7:0]  c_lat_r;

    reg         ifull_a_r;
    reg         ofull_a_n_r;
    reg         req_a_r;
    reg         ifull_b_r;
    reg         ofull_b_n_r;
    reg         req_b_r;
    reg         bidir_in_request_enable_r;
    reg         bidir_out_request_enable_r;
    reg         group_b_request_enable_r;

    reg  [7:0]  hs_out;
    reg  [7:0]  hs_in;
    reg  [7:0]  hs_val;
    reg  [7:0]  c_out_nxt;
    reg  [7:0]  c_oe_n_nxt;
    reg  [7:0]  c_rd;
    reg  [7:0]  rd_nxt;
    reg         c_dir_in;
    integer     i;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ppm_sync #(
        .W       (24)
    ) u_sync (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .pin_in  ({third_port_line_in, second_port_line_in, first_port_line_in}),
        .pin_out (pins_s)
    );

    assign pa_s = pins_s[7:0];
    assign pb_s = pins_s[15:8];
    assign pc_s = pins_s[23:16];

    // ------------------------------------------------------------
    // Decoded modes and host accesses
    // ------------------------------------------------------------
    // strobed sides of group A
    wire a_strobed = (a_mode_r == `PPM_AMODE_STROBE);
    wire a_bidir   = a_mode_r[1];
    wire a_in_side  = (a_strobed & a_dir_in_r) | a_bidir;
    wire a_out_side = (a_strobed & ~a_dir_in_r) | a_bidir;
    // group B strobed side chosen by its own bit
    wire b_in_side  = b_mode_r & b_dir_in_r;
    wire b_out_side = b_mode_r & ~b_dir_in_r;

    wire wr_a     = wr_stb & (port_select == `PPM_SEL_A);
    wire wr_b     = wr_stb & (port_select == `PPM_SEL_B);
    wire wr_c     = wr_stb & (port_select == `PPM_SEL_C);
    wire wr_ctl   = wr_stb & (port_select == `PPM_SEL_CTRL);
    wire rd_a     = rd_stb & (port_select == `PPM_SEL_A);
    wire rd_b     = rd_stb & (port_select == `PPM_SEL_B);
    wire mode_set = wr_ctl & wr_data[`PPM_CW_MODE_SET];
    wire bit_op   = wr_ctl & ~wr_data[`PPM_CW_MODE_SET];
    wire [2:0] bit_sel = wr_data[`PPM_CW_BIT_HI:`PPM_CW_BIT_LO];
    wire bit_val  = wr_data[`PPM_CW_BIT_VAL];

    // Handshake inputs after synchronisation
    wire stb_a_n = pc_s[`PPM_PC_STB_A];
    wire ack_a_n = pc_s[`PPM_PC_ACK_A];
    wire hs_b_n  = pc_s[`PPM_PC_STB_B];

    // ------------------------------------------------------------
    // Port C line roles and values
    // ------------------------------------------------------------
    // handshake line assignment per mode
    always @* begin
        hs_out = 8'h00;
        hs_in  = 8'h00;
        hs_val = 8'h00;
        if (a_in_side) begin
            hs_out[`PPM_PC_REQ_A] = 1'b1;
            hs_out[`PPM_PC_IFULL_A] = 1'b1;
            hs_in[`PPM_PC_STB_A]  = 1'b1;
        end
        if (a_out_side) begin
            hs_out[`PPM_PC_REQ_A] = 1'b1;
            hs_out[`PPM_PC_OFULL_A] = 1'b1;
            hs_in[`PPM_PC_ACK_A]  = 1'b1;
        end
        if (b_mode_r) begin
            hs_out[`PPM_PC_REQ_B]  = 1'b1;
            hs_out[`PPM_PC_FULL_B] = 1'b1;
            hs_in[`PPM_PC_STB_B]   = 1'b1;
        end
        hs_val[`PPM_PC_REQ_A]   = req_a_r;
        hs_val[`PPM_PC_IFULL_A] = ifull_a_r;
        hs_val[`PPM_PC_OFULL_A] = ofull_a_n_r;
        hs_val[`PPM_PC_REQ_B]   = req_b_r;
        hs_val[`PPM_PC_FULL_B]  = b_dir_in_r ? ifull_b_r : ofull_b_n_r;
    end

    // Per-line drive, enable and read value of port C
    always @* begin
        c_out_nxt  = 8'h00;
        c_oe_n_nxt = 8'h00;
        c_rd       = 8'h00;
        c_dir_in   = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            // nibble direction bits, one means input
            c_dir_in = (i >= 4) ? cu_dir_in_r : cl_dir_in_r;
            if (hs_out[i]) begin
                c_out_nxt[i]  = hs_val[i];
                c_oe_n_nxt[i] = 1'b0;
                c_rd[i]       = hs_val[i];
            end else if (hs_in[i] | c_dir_in) begin
                c_out_nxt[i]  = c_lat_r[i];
                c_oe_n_nxt[i] = 1'b1;
                c_rd[i]       = pc_s[i];
            end else begin
                c_out_nxt[i]  = c_lat_r[i];
                c_oe_n_nxt[i] = 1'b0;
                c_rd[i]       = c_lat_r[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always @* begin
        case (port_select)
            `PPM_SEL_A: begin
                // basic input unlatched, strobed input latched
                if (a_mode_r == `PPM_AMODE_BASIC) begin
                    rd_nxt = a_dir_in_r ? pa_s : first_port_line_out;
                end else begin
                    rd_nxt = a_in_side ? a_in_r : first_port_line_out;
                end
            end
            `PPM_SEL_B: begin
                if (!b_mode_r) begin
                    rd_nxt = b_dir_in_r ? pb_s : b_out_r;
                end else begin
                    rd_nxt = b_in_side ? b_in_r : b_out_r;
                end
            end
            `PPM_SEL_C: begin
                rd_nxt = c_rd;
            end
            default: begin
                rd_nxt = `PPM_RDATA_RST;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Control word and data latches
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            a_mode_r    <= `PPM_AMODE_RST;
            b_mode_r    <= `PPM_BMODE_RST;
            a_dir_in_r  <= `PPM_DIR_RST;
            b_dir_in_r  <= `PPM_DIR_RST;
            cu_dir_in_r <= `PPM_DIR_RST;
            cl_dir_in_r <= `PPM_DIR_RST;
            first_port_line_out <= `PPM_LATCH_RST;
            b_out_r     <= `PPM_LATCH_RST;
            c_lat_r     <= `PPM_LATCH_RST;
            a_in_r      <= `PPM_LATCH_RST;
            b_in_r      <= `PPM_LATCH_RST;
        end else if (ce) begin
            if (mode_set) begin
                a_mode_r    <= wr_data[`PPM_CW_AMODE_HI:`PPM_CW_AMODE_LO];
                b_mode_r    <= wr_data[`PPM_CW_B_MODE];
                a_dir_in_r  <= wr_data[`PPM_CW_A_DIR];
                b_dir_in_r  <= wr_data[`PPM_CW_B_DIR];
                cu_dir_in_r <= wr_data[`PPM_CW_CU_DIR];
                cl_dir_in_r <= wr_data[`PPM_CW_CL_DIR];
                first_port_line_out <= `PPM_LATCH_RST;
                b_out_r     <= `PPM_LATCH_RST;
                c_lat_r     <= `PPM_LATCH_RST;
            end else begin
                if (wr_a) begin
                    first_port_line_out <= wr_data;
                end
                if (wr_b) begin
                    b_out_r <= wr_data;
                end
                if (wr_c) begin
                    c_lat_r[3:0] <= wr_data[3:0];
                    // upper nibble only in basic mode
                    if (a_mode_r == `PPM_AMODE_BASIC) begin
                        c_lat_r[7:4] <= wr_data[7:4];
                    end
                end
                if (bit_op) begin
                    c_lat_r[bit_sel] <= bit_val;
                end
            end
            // capture pins while load strobe low
            if (a_in_side & ~stb_a_n) begin
                a_in_r <= pa_s;
            end
            if (b_in_side & ~hs_b_n) begin
                b_in_r <= pb_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Handshake flags and request enables
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            ifull_a_r   <= 1'b0;
            ofull_a_n_r <= 1'b1;
            req_a_r     <= 1'b0;
            ifull_b_r   <= 1'b0;
            ofull_b_n_r <= 1'b1;
            req_b_r   <= 1'b0;
            bidir_in_request_enable_r  <= 1'b0;
            bidir_out_request_enable_r <= 1'b0;
            group_b_request_enable_r   <= 1'b0;
        end else if (ce) begin
            if (mode_set) begin
                // mode set clears flags and enables
                ifull_a_r   <= 1'b0;
                ofull_a_n_r <= 1'b1;
                req_a_r     <= 1'b0;
                ifull_b_r   <= 1'b0;
                ofull_b_n_r <= 1'b1;
                req_b_r   <= 1'b0;
                bidir_in_request_enable_r  <= 1'b0;
                bidir_out_request_enable_r <= 1'b0;
                group_b_request_enable_r   <= 1'b0;
            end else begin
                // input full, strobe wins over read
                if (a_in_side & ~stb_a_n) begin
                    ifull_a_r <= 1'b1;
                end else if (rd_a) begin
                    ifull_a_r <= 1'b0;
                end
                if (b_in_side & ~hs_b_n) begin
                    ifull_b_r <= 1'b1;
                end else if (rd_b) begin
                    ifull_b_r <= 1'b0;
                end
                // write drives output full flag low, acceptance restores
                if (a_out_side & wr_a) begin
                    ofull_a_n_r <= 1'b0;
                end else if (~ack_a_n) begin
                    ofull_a_n_r <= 1'b1;
                end
                if (b_out_side & wr_b) begin
                    ofull_b_n_r <= 1'b0;
                end else if (~hs_b_n) begin
                    ofull_b_n_r <= 1'b1;
                end
                // input request after strobe returns high
                req_a_r <= ((a_in_side & stb_a_n & ifull_a_r & bidir_in_request_enable_r)
                          | (a_out_side & ack_a_n & ofull_a_n_r
                             & bidir_out_request_enable_r))
                          & ~(rd_a | wr_a);
                req_b_r <= ((b_in_side & hs_b_n & ifull_b_r)
                          | (b_out_side & hs_b_n & ofull_b_n_r))
                          & group_b_request_enable_r & ~(rd_b | wr_b);
                // group A request enables on lines four and six, group B on line two
                if (bit_op) begin
                    if ((bit_sel == `PPM_PC_STB_A) & a_in_side) begin
                        bidir_in_request_enable_r <= bit_val;
                    end
                    if ((bit_sel == `PPM_PC_ACK_A) & a_out_side) begin
                        bidir_out_request_enable_r <= bit_val;
                    end
                    if ((bit_sel == `PPM_PC_STB_B) & b_mode_r) begin
                        group_b_request_enable_r <= bit_val;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers and read data register
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            first_port_line_oe_n  <= `PPM_OE_N_RST;
            second_port_line_out  <= `PPM_LATCH_RST;
            second_port_line_oe_n <= `PPM_OE_N_RST;
            third_port_line_out   <= `PPM_LATCH_RST;
            third_port_line_oe_n  <= `PPM_OE_N_RST;
            rd_data               <= `PPM_RDATA_RST;
        end else if (ce) begin
            // bidirectional drive only while acceptance low
            if (a_bidir) begin
                first_port_line_oe_n <= {8{ack_a_n}};
            end else begin
                // byte ports each set as a whole
                first_port_line_oe_n <= {8{a_dir_in_r}};
            end
            second_port_line_out  <= b_out_r;
            second_port_line_oe_n <= {8{b_dir_in_r}};
            third_port_line_out   <= c_out_nxt;
            third_port_line_oe_n  <= c_oe_n_nxt;
            rd_data <= rd_stb ? rd_nxt : `PPM_RDATA_RST;
        end
    end

    // group split shown by the role masks above
    // strobed data held in a_in_r, b_in_r and out latches
    // bidirectional input latch shares group A input path
    // acceptance input sampled as ack_a_n and hs_b_n

endmodule
`default_nettype wire

// *** inc/ppm_consts.vh ***
// Constants for the three-port programmable parallel port block
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH

// ------------------------------------------------------------
// Port select codes
// ------------------------------------------------------------
`define PPM_SEL_A        2'h0
`define PPM_SEL_B        2'h1
`define PPM_SEL_C        2'h2
`define PPM_SEL_CTRL     2'h3

// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
`define PPM_CW_MODE_SET  7
`define PPM_CW_AMODE_HI  6
`define PPM_CW_AMODE_LO  5
`define PPM_CW_A_DIR     4
`define PPM_CW_CU_DIR    3
`define PPM_CW_B_MODE    2
`define PPM_CW_B_DIR     1
`define PPM_CW_CL_DIR    0
`define PPM_CW_BIT_HI    3
`define PPM_CW_BIT_LO    1
`define PPM_CW_BIT_VAL   0

// ------------------------------------------------------------
// Group A mode codes
// ------------------------------------------------------------
`define PPM_AMODE_BASIC  2'h0
`define PPM_AMODE_STROBE 2'h1

// ------------------------------------------------------------
// Third port handshake line positions
// ------------------------------------------------------------
`define PPM_PC_REQ_B     3'h0
`define PPM_PC_FULL_B    3'h1
`define PPM_PC_STB_B     3'h2
`define PPM_PC_REQ_A     3'h3
`define PPM_PC_STB_A     3'h4
`define PPM_PC_IFULL_A   3'h5
`define PPM_PC_ACK_A     3'h6
`define PPM_PC_OFULL_A   3'h7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PPM_AMODE_RST    2'h0
`define PPM_BMODE_RST    1'h0
`define PPM_DIR_RST      1'h1
`define PPM_LATCH_RST    8'h00
`define PPM_OE_N_RST     8'hFF
`define PPM_RDATA_RST    8'h00
`define PPM_SYNC_RST     1'h1

`endif

// *** hdl/ppm_sync.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"

module ppm_sync #(
    parameter W = 24
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire         ce,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] pin_out
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer     i;

    // Stage chain; output follows only where stages two and three agree
    always @(posedge clk) begin
        if (!nrst) begin
            s1_r    <= {W{`PPM_SYNC_RST}};
            s2_r    <= {W{`PPM_SYNC_RST}};
            s3_r    <= {W{`PPM_SYNC_RST}};
            pin_out <= {W{`PPM_SYNC_RST}};
        end else if (ce) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_out[i] <= s3_r[i];
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** sim/ppm_properties.sv ***
// Port checker for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module ppm_properties (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       ce,
    input wire logic [1:0] port_select,
    input wire logic [7:0] wr_data,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] first_port_line_in,
    input wire logic [7:0] first_port_line_out,
    input wire logic [7:0] first_port_line_oe_n,
    input wire logic [7:0] second_port_line_in,
    input wire logic [7:0] second_port_line_out,
    input wire logic [7:0] second_port_line_oe_n,
    input wire logic [7:0] third_port_line_in,
    input wire logic [7:0] third_port_line_out,
    input wire logic [7:0] third_port_line_oe_n
);
    logic [7:0] cw_r;
    wire        b_in1  = cw_r[2] & cw_r[1];
    wire        b_out1 = cw_r[2] & ~cw_r[1];
    wire        a_in1  = (cw_r[6:5] == 2'h1) & cw_r[4];
    wire        bidir  = cw_r[6];

    // Last mode word taken from the host
    always @(posedge clk) begin
        if (!nrst)
            cw_r <= 8'h9B;
        else if (ce && wr_stb && port_select == 2'h3 && wr_data[7])
            cw_r <= wr_data;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_b_read;
        b_in1 && rd_stb && port_select == 2'h1;
    endsequence
    sequence s_b_write;
        b_out1 && wr_stb && port_select == 2'h1;
    endsequence
    sequence s_b_stb_low;
        (b_in1 && !third_port_line_in[2]) [*7];
    endsequence

    a_reset_float:
        assert property ($rose(nrst) |-> (first_port_line_oe_n & second_port_line_oe_n
            & third_port_line_oe_n) == 8'hFF) else $error("Lines driven after reset");
    a_rdata_idle:
        assert property (!rd_stb |=> rd_data == 8'h00) else $error("Read data not idle");
    a_ctrl_unread:
        assert property (rd_stb && port_select == 2'h3 |=> rd_data == 8'h00)
            else $error("Control word readable");
    a_a_out_held:
        assert property ($changed(first_port_line_out) |-> $past(wr_stb) || $past(wr_stb, 2))
            else $error("Port A latch moved without write");
    a_b_dir_whole:
        assert property (second_port_line_oe_n == 8'h00 || second_port_line_oe_n == 8'hFF)
            else $error("Port B direction split");
    a_b_full_set:
        assert property (s_b_stb_low |-> third_port_line_out[1]) else $error("Input full not set");
    a_b_req_read:
        assert property (s_b_read |-> ##[1:2] !third_port_line_out[0])
            else $error("Request not cleared by read");
    a_b_full_wr:
        assert property (s_b_write |-> ##[1:3] !third_port_line_out[1])
            else $error("Output full not driven low");
    a_b_req_wr:
        assert property (s_b_write |-> ##[1:2] !third_port_line_out[0])
            else $error("Request not cleared by write");
    a_c_upper_kept:
        assert property (a_in1 && wr_stb && port_select == 2'h2 |=>
            $stable(third_port_line_out[7:6]) [*2]) else $error("Spare upper moved on word");
    a_bidir_float:
        assert property ((bidir && third_port_line_in[6]) [*7] |-> first_port_line_oe_n == 8'hFF)
            else $error("Port A driven without acceptance");
endmodule

bind ppm_top ppm_properties chk_i (
    .clk, .nrst, .ce, .port_select, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .first_port_line_in, .first_port_line_out, .first_port_line_oe_n,
    .second_port_line_in, .second_port_line_out, .second_port_line_oe_n,
    .third_port_line_in, .third_port_line_out, .third_port_line_oe_n
);
`default_nettype wire

// *** sim/ppm_periph.sv ***
// Peripheral model on the port pins
`timescale 1ns/1ps
`default_nettype none
module ppm_periph (
    input  wire logic [7:0] a_pin,
    input  wire logic [7:0] b_pin,
    input  wire logic       clk,
    output logic      [7:0] a_drv,
    output logic      [7:0] b_drv,
    output logic      [7:0] c_drv
);
    logic [7:0] taken;

    // Idle data lines low, strobes and acceptances high
    initial begin
        a_drv = 8'h00;
        b_drv = 8'h00;
        c_drv = 8'hFF;
        taken = 8'h00;
    end

    task automatic lines(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        a_drv <= a;
        b_drv <= b;
        c_drv <= c;
    endtask

    task automatic strobe(input logic ga, input logic [7:0] d, input int n);
        if (ga) a_drv <= d; else b_drv <= d;
        @(posedge clk);
        c_drv[ga ? 4 : 2] <= 1'b0;
        repeat (n) @(posedge clk);
        c_drv[ga ? 4 : 2] <= 1'b1;
        repeat (4) @(posedge clk);
        if (ga) a_drv <= ~d; else b_drv <= ~d;
    endtask

    task automatic accept(input logic ga, input int dly);
        repeat (dly) @(posedge clk);
        c_drv[ga ? 6 : 2] <= 1'b0;
        repeat (8) @(posedge clk);
        taken = ga ? a_pin : b_pin;
        c_drv[ga ? 6 : 2] <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"
module tb;
    logic       clk, nrst, ce, wr_stb, rd_stb;
    logic [1:0] port_select;
    logic [7:0] wr_data, x, y, e, dm;
    logic [7:0] q[$];
    int         miscompares, cmp_count, seed, m;
    wire  [7:0] rd_data, a_d, b_d, c_d;
    wire  [7:0] first_port_line_in, first_port_line_out, first_port_line_oe_n;
    wire  [7:0] second_port_line_in, second_port_line_out, second_port_line_oe_n;
    wire  [7:0] third_port_line_in, third_port_line_out, third_port_line_oe_n;

    function automatic logic [7:0] res(input logic [7:0] o, oe, d);
        return (~oe & o) | (oe & d);
    endfunction
    // Pin level from both drivers
    assign first_port_line_in  = res(first_port_line_out, first_port_line_oe_n, a_d);
    assign second_port_line_in = res(second_port_line_out, second_port_line_oe_n, b_d);
    assign third_port_line_in  = res(third_port_line_out, third_port_line_oe_n, c_d);

    ppm_top uut (
        .clk, .nrst, .ce, .port_select, .wr_data, .wr_stb, .rd_stb, .rd_data,
        .first_port_line_in, .first_port_line_out, .first_port_line_oe_n,
        .second_port_line_in, .second_port_line_out, .second_port_line_oe_n,
        .third_port_line_in, .third_port_line_out, .third_port_line_oe_n
    );
    ppm_periph per (
        .clk, .a_pin(first_port_line_in), .b_pin(second_port_line_in),
        .a_drv(a_d), .b_drv(b_d), .c_drv(c_d)
    );

    // Clock at 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        cmp_count++;
        if (got !== ex) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        port_select <= s;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] ex, input string nm);
        port_select <= s;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        chk(nm, ex, rd_data);
        @(posedge clk);
    endtask
    task automatic wait_bit(input int b, input logic v, input string nm);
        int k;
        @(negedge clk);
        for (k = 0; k < 40 && third_port_line_out[b] !== v; k++) @(negedge clk);
        chk(nm, {7'h00, v}, {7'h00, third_port_line_out[b]});
        if (k == 40) test_done();
        @(posedge clk);
    endtask

    // Cut a hang short
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        test_done();
    end

    // Main sequence
    initial begin
        seed = 32'h75E2C1B7;
        {nrst, wr_stb, rd_stb, port_select, wr_data} = '0;
        ce = 1'b1;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("oe_reset", 8'hFF, first_port_line_oe_n & second_port_line_oe_n);
        chk("c_oe_reset", 8'hFF, third_port_line_oe_n);
        rd(`PPM_SEL_CTRL, 8'h00, "ctrl_read");
        // Basic mode over every direction set
        for (m = 0; m < 16; m++) begin
            x = $random(seed);
            y = $random(seed);
            dm = {{4{m[2]}}, {4{m[0]}}};
            e = (dm & (x ^ 8'hC3)) | (~dm & (y ^ 8'h3C));
            per.lines(x, ~x, x ^ 8'hC3);
            wr(`PPM_SEL_CTRL, {3'h4, m[3], m[2], 1'b0, m[1], m[0]});
            wr(`PPM_SEL_A, y);
            wr(`PPM_SEL_B, ~y);
            wr(`PPM_SEL_C, y ^ 8'h3C);
            repeat (8) @(posedge clk);
            chk("a_oe", {8{m[3]}}, first_port_line_oe_n);
            chk("b_oe", {8{m[1]}}, second_port_line_oe_n);
            chk("c_oe", dm, third_port_line_oe_n);
            chk("c_pins", e, third_port_line_in);
            rd(`PPM_SEL_A, m[3] ? x : y, "a_basic");
            rd(`PPM_SEL_B, m[1] ? ~x : ~y, "b_basic");
            rd(`PPM_SEL_C, e, "c_basic");
        end
        // Strobed input on group B
        per.lines(8'h00, 8'h00, 8'hFF);
        wr(`PPM_SEL_CTRL, 8'h9F);
        wr(`PPM_SEL_CTRL, 8'h05);
        x = $random(seed);
        q.push_back(x);
        per.strobe(1'b0, x, 8);
        wait_bit(1, 1'b1, "b_in_full");
        wait_bit(0, 1'b1, "b_in_req");
        rd(`PPM_SEL_B, q.pop_front(), "b_latch");
        wait_bit(0, 1'b0, "b_req_read");
        wait_bit(1, 1'b0, "b_full_read");
        wr(`PPM_SEL_CTRL, 8'h04);
        per.strobe(1'b0, ~x, 8);
        wait_bit(1, 1'b1, "b_full_again");
        repeat (4) @(posedge clk);
        wait_bit(0, 1'b0, "b_req_masked");
        wr(`PPM_SEL_CTRL, 8'h9F);
        wait_bit(1, 1'b0, "b_full_mode_set");
        // Strobed output on group B
        wr(`PPM_SEL_CTRL, 8'h9C);
        wr(`PPM_SEL_CTRL, 8'h05);
        wait_bit(0, 1'b1, "b_out_req_empty");
        y = $random(seed);
        wr(`PPM_SEL_B, y);
        wait_bit(1, 1'b0, "b_full_n_low");
        wait_bit(0, 1'b0, "b_req_write");
        chk("b_out_pins", y, second_port_line_in);
        per.accept(1'b0, 3);
        chk("b_taken", y, per.taken);
        wait_bit(1, 1'b1, "b_full_n_back");
        wait_bit(0, 1'b1, "b_req_again");
        wr(`PPM_SEL_C, 8'hFF);
        wait_bit(3, 1'b1, "c3_word");
        wr(`PPM_SEL_CTRL, 8'h06);
        wait_bit(3, 1'b0, "c3_bit_reset");
        // Strobed input on group A with spare upper outputs
        wr(`PPM_SEL_CTRL, 8'hB3);
        wr(`PPM_SEL_C, 8'hC0);
        repeat (2) @(posedge clk);
        wait_bit(7, 1'b0, "c7_word_kept");
        wr(`PPM_SEL_CTRL, 8'h0F);
        wait_bit(7, 1'b1, "c7_bit_set");
        wr(`PPM_SEL_CTRL, 8'h09);
        x = $random(seed);
        q.push_back(x);
        per.strobe(1'b1, x, 8);
        wait_bit(5, 1'b1, "a_in_full");
        wait_bit(3, 1'b1, "a_in_req");
        rd(`PPM_SEL_A, q.pop_front(), "a_latch");
        // Bidirectional bus on port A
        wr(`PPM_SEL_CTRL, 8'hC0);
        repeat (8) @(posedge clk);
        chk("a_float", 8'hFF, first_port_line_oe_n);
        wr(`PPM_SEL_CTRL, 8'h0D);
        y = $random(seed);
        wr(`PPM_SEL_A, y);
        wait_bit(7, 1'b0, "bidir_full_n");
        per.accept(1'b1, 2);
        chk("a_bus", y, per.taken);
        wait_bit(7, 1'b1, "bidir_full_n_back");
        wait_bit(3, 1'b1, "bidir_req_out");
        wr(`PPM_SEL_CTRL, 8'h09);
        x = $random(seed);
        q.push_back(x);
        per.strobe(1'b1, x, 8);
        wait_bit(5, 1'b1, "bidir_full");
        rd(`PPM_SEL_A, q.pop_front(), "bidir_in");
        test_done();
    end
endmodule
`default_nettype wire
